// *** verilog/instr_exec_regs.vh ***
// constants for the instruction subset execution datapath
// assumes the core supplies decoded operation codes and memory read data
// Overview of operation
// - subtract immediate from work register, update flags
// - swap nibbles of memory byte in place
// - swapped memory byte goes to work register
// - skip next instruction when memory byte zero
// - taken skip inserts one dummy cycle
// - copy byte to work register, skip if zero
// - skip next instruction when selected bit zero
// - table read current page into memory, high byte
// - table read last page, same otherwise
// - xor memory into work register, zero flag only
// - xor result written back to memory, zero flag
// - xor immediate into work register, zero flag
`ifndef INSTR_EXEC_REGS_VH
`define INSTR_EXEC_REGS_VH
`define OP_NOP 4'h0
`define OP_SUB_IMM 4'h1
`define OP_SWAP 4'h2
`define OP_SWAP_TO_WORK 4'h3
`define OP_SKIP_ZERO 4'h4
`define OP_COPY_SKIP_ZERO 4'h5
`define OP_SKIP_BIT_ZERO 4'h6
`define OP_TABLE_CURRENT 4'h7
`define OP_TABLE_LAST 4'h8
`define OP_XOR_MEM 4'h9
`define OP_XOR_INTO_MEM 4'ha
`define OP_XOR_IMM 4'hb
`define FLAG_C 0
`define FLAG_AC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAGS_RESET 4'h0
`define WORK_RESET 8'h00
`define TABLE_HIGH_RESET 8'h00
`define PROG_ADDR_RESET 14'h0000
`define PAGE_LAST 6'h3f
`endif

// *** verilog/sub_flags.v ***
// 8-bit subtractor producing result and the four arithmetic flags
// purely combinational, used by the execution datapath
`timescale 1ns/1ns
module sub_flags (
   // operands
   input wire [7:0] a,
   input wire [7:0] b,
   // results
   output wire [7:0] diff,
   output wire carry,
   output wire half_carry,
   output wire overflow,
   output wire zero
);
   wire [8:0] full;
   wire [4:0] low;
   // carry means no borrow
   assign full = {1'b0, a} + {1'b0, ~b} + 9'h001;
   assign low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
   assign diff = full[7:0];
   assign carry = full[8];
   assign half_carry = low[4];
   assign overflow = (a[7] ^ b[7]) & (a[7] ^ full[7]);
   assign zero = (full[7:0] == 8'h00);
endmodule

// *** verilog/instr_exec.v ***
// execution datapath for a subset of 8-bit core instructions
// assumes one op per cycle when op_valid, memory data valid with the op
`timescale 1ns/1ns
`include "instr_exec_regs.vh"
module instr_exec (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // decoded instruction
   input wire op_valid,
   input wire [3:0] op_code,
   input wire [7:0] imm_operand,
   input wire [2:0] bit_select,
   input wire [8:0] mem_addr,
   input wire [7:0] mem_rdata,
   // table read
   input wire [7:0] table_pointer,
   input wire [5:0] pc_page,
   input wire [15:0] prog_rdata,
   // program memory address for table reads
   output reg [13:0] prog_addr,
   // data memory write
   output reg mem_we,
   output reg [8:0] mem_waddr,
   output reg [7:0] mem_wdata,
   // architectural state
   output reg [7:0] work_register,
   output reg [3:0] flags,
   output reg [7:0] table_high_byte_reg,
   // sequencing
   output reg skip_pending,
   output reg dummy_cycle
);
   // two-cycle ops park in one of two extra states for their second cycle
   localparam ST_RUN = 2'h0;
   localparam ST_TABLE = 2'h1;
   localparam ST_SKIP = 2'h2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [8:0] table_dest_reg;
   // next values of the registered outputs
   reg [7:0] work_next;
   reg [3:0] flags_next;
   reg [7:0] high_next;
   reg [13:0] prog_addr_next;
   reg we_next;
   reg [8:0] waddr_next;
   reg [7:0] wdata_next;
   reg skip_next;
   reg [8:0] dest_next;
   // subtractor results
   wire [7:0] diff;
   wire sub_c;
   wire sub_ac;
   wire sub_ov;
   wire sub_z;
   wire [7:0] xor_mem;
   wire [7:0] xor_imm;
   wire [7:0] swapped;
   wire execute;
   // zero tests shared by the skip and xor ops
   wire mem_zero;
   wire xor_mem_zero;
   wire xor_imm_zero;
   wire bit_clear;

   sub_flags u_sub (
      .a(work_register),
      .b(imm_operand),
      .diff(diff),
      .carry(sub_c),
      .half_carry(sub_ac),
      .overflow(sub_ov),
      .zero(sub_z)
   );

   // ops read memory in the cycle they are taken, so operands are combinational
   assign xor_mem = work_register ^ mem_rdata;
   assign xor_imm = work_register ^ imm_operand;
   assign swapped = {mem_rdata[3:0], mem_rdata[7:4]};
   // the fetched instruction after a taken skip is dropped here
   assign execute = op_valid && (state_reg == ST_RUN);
   assign mem_zero = (mem_rdata == 8'h00);
   assign xor_mem_zero = (xor_mem == 8'h00);
   assign xor_imm_zero = (xor_imm == 8'h00);
   assign bit_clear = ~mem_rdata[bit_select];

   // decode; flags keep their value unless the op names them
   always @* begin
      state_next = ST_RUN;
      work_next = work_register;
      flags_next = flags;
      high_next = table_high_byte_reg;
      prog_addr_next = prog_addr;
      we_next = 1'b0;
      waddr_next = mem_addr;
      wdata_next = mem_wdata;
      skip_next = 1'b0;
      dest_next = table_dest_reg;
      case (state_reg)
         ST_RUN: begin
            if (execute) begin
               case (op_code)
                  `OP_SUB_IMM: begin
                     work_next = diff;
                     flags_next[`FLAG_C] = sub_c;
                     flags_next[`FLAG_AC] = sub_ac;
                     flags_next[`FLAG_OV] = sub_ov;
                     flags_next[`FLAG_Z] = sub_z;
                  end
                  `OP_SWAP: begin
                     we_next = 1'b1;
                     wdata_next = swapped;
                  end
                  `OP_SWAP_TO_WORK: begin
                     work_next = swapped;
                  end
                  `OP_SKIP_ZERO: begin
                     skip_next = mem_zero;
                  end
                  `OP_COPY_SKIP_ZERO: begin
                     work_next = mem_rdata;
                     skip_next = mem_zero;
                  end
                  `OP_SKIP_BIT_ZERO: begin
                     skip_next = bit_clear;
                  end
                  `OP_TABLE_CURRENT: begin
                     prog_addr_next = {pc_page, table_pointer};
                     dest_next = mem_addr;
                     state_next = ST_TABLE;
                  end
                  `OP_TABLE_LAST: begin
                     prog_addr_next = {`PAGE_LAST, table_pointer};
                     dest_next = mem_addr;
                     state_next = ST_TABLE;
                  end
                  `OP_XOR_MEM: begin
                     work_next = xor_mem;
                     flags_next[`FLAG_Z] = xor_mem_zero;
                  end
                  `OP_XOR_INTO_MEM: begin
                     we_next = 1'b1;
                     wdata_next = xor_mem;
                     flags_next[`FLAG_Z] = xor_mem_zero;
                  end
                  `OP_XOR_IMM: begin
                     work_next = xor_imm;
                     flags_next[`FLAG_Z] = xor_imm_zero;
                  end
                  // nop and unused codes change nothing
                  default: begin
                     work_next = work_register;
                  end
               endcase
               if (skip_next) begin
                  state_next = ST_SKIP;
               end
            end
         end
         ST_TABLE: begin
            // second cycle: program word is back
            // the op presented in this cycle is ignored
            we_next = 1'b1;
            waddr_next = table_dest_reg;
            wdata_next = prog_rdata[7:0];
            high_next = prog_rdata[15:8];
         end
         ST_SKIP: begin
            // the op fetched behind the skip is dropped by execute
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // sequencing state
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_RUN;
         skip_pending <= 1'b0;
         dummy_cycle <= 1'b0;
      end else begin
         state_reg <= state_next;
         skip_pending <= skip_next;
         dummy_cycle <= (state_next == ST_SKIP);
      end
   end

   // architectural registers
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         work_register <= `WORK_RESET;
         flags <= `FLAGS_RESET;
         table_high_byte_reg <= `TABLE_HIGH_RESET;
      end else begin
         work_register <= work_next;
         flags <= flags_next;
         table_high_byte_reg <= high_next;
      end
   end

   // memory ports; strobe lags the op a cycle so write data leaves a clean register
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prog_addr <= `PROG_ADDR_RESET;
         mem_we <= 1'b0;
         mem_waddr <= 9'h000;
         mem_wdata <= 8'h00;
         table_dest_reg <= 9'h000;
      end else begin
         prog_addr <= prog_addr_next;
         mem_we <= we_next;
         mem_waddr <= waddr_next;
         mem_wdata <= wdata_next;
         table_dest_reg <= dest_next;
      end
   end
endmodule

// *** test/instr_exec_asserts.sv ***
// checker for instr_exec: ties each result to its operands
// assumes ops in the gap after a table read or taken skip are ignored
`timescale 1ns/1ns
`include "instr_exec_regs.vh"
module instr_exec_asserts (
   // inputs of the block
   input wire logic core_clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic [7:0] imm_operand,
   input wire logic [2:0] bit_select,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] table_pointer,
   input wire logic [15:0] prog_rdata,
   // outputs of the block
   input wire logic [13:0] prog_addr,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] work_register,
   input wire logic [3:0] flags,
   input wire logic [7:0] table_high_byte_reg,
   input wire logic skip_pending,
   input wire logic dummy_cycle
);
   logic tbl_reg;
   wire go = op_valid && !dummy_cycle && !tbl_reg;
   wire sel_bit = mem_rdata[bit_select];
   wire [7:0] swapped = {mem_rdata[3:0], mem_rdata[7:4]};
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // tracks the data phase of a table read, which the block does not expose
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         tbl_reg <= 1'b0;
      else
         tbl_reg <= go && (op_code == `OP_TABLE_CURRENT || op_code == `OP_TABLE_LAST);
   end
   sub_result_a: assert property (go && op_code == `OP_SUB_IMM |=>
      work_register == $past(work_register) - $past(imm_operand)
      && flags[`FLAG_C] == ($past(work_register) >= $past(imm_operand))) else $error("sub bad");
   swap_mem_a: assert property (go && op_code == `OP_SWAP |=>
      mem_we && mem_wdata == $past(swapped) && $stable(flags)) else $error("swap bad");
   swap_work_a: assert property (go && op_code == `OP_SWAP_TO_WORK |=>
      work_register == $past(swapped) && !mem_we && $stable(flags)) else $error("nibble_swap_to_work_reg bad");
   zero_skip_a: assert property (go && op_code inside {`OP_SKIP_ZERO, `OP_COPY_SKIP_ZERO}
      |=> skip_pending == ($past(mem_rdata) == 8'h00) && $stable(flags)) else $error("sz bad");
   dummy_once_a: assert property (skip_pending |-> dummy_cycle ##1 !dummy_cycle)
      else $error("dummy bad");
   bit_skip_a: assert property (go && op_code == `OP_SKIP_BIT_ZERO |=>
      skip_pending == !$past(sel_bit)) else $error("bit skip bad");
   table_data_a: assert property (tbl_reg |=> mem_we
      && {table_high_byte_reg, mem_wdata} == $past(prog_rdata)) else $error("table bad");
   last_page_a: assert property (go && op_code == `OP_TABLE_LAST |=>
      prog_addr == {`PAGE_LAST, $past(table_pointer)}) else $error("last page bad");
   copy_skip_a: assert property (go && op_code == `OP_COPY_SKIP_ZERO |=>
      work_register == $past(mem_rdata) && $stable(flags)) else $error("copy skip bad");
   xor_imm_a: assert property (go && op_code == `OP_XOR_IMM |=>
      work_register == ($past(work_register) ^ $past(imm_operand))
      && flags[`FLAG_Z] == (work_register == 8'h00)) else $error("xor imm bad");
   quiet_dummy_a: assert property (dummy_cycle |=>
      $stable(work_register) && $stable(flags) && !mem_we) else $error("skipped op ran");
endmodule
bind instr_exec instr_exec_asserts instr_exec_asserts_i (.core_clk, .rst, .op_valid, .op_code,
   .imm_operand, .bit_select, .mem_rdata, .table_pointer, .prog_rdata, .prog_addr, .mem_we,
   .mem_wdata, .work_register, .flags, .table_high_byte_reg, .skip_pending, .dummy_cycle);

// *** test/tb_top.sv ***
// self-checking bench for instr_exec, one op per clock
// assumes instr_exec_regs.vh is on the include path
`timescale 1ns/1ns
`include "instr_exec_regs.vh"
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   logic [3:0] op_code = 4'h0;
   logic [7:0] imm_operand = 8'h00;
   logic [7:0] mem_rdata = 8'h00;
   logic [2:0] bit_select = 3'h3;
   logic [8:0] mem_addr = 9'h012;
   logic [7:0] table_pointer = 8'h34;
   logic [5:0] pc_page = 6'h05;
   logic [15:0] prog_rdata = 16'h0000;
   wire [13:0] prog_addr;
   wire mem_we, skip_pending, dummy_cycle;
   wire [8:0] mem_waddr;
   wire [7:0] mem_wdata, work_register, table_high_byte_reg;
   wire [3:0] flags;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   always #5 core_clk = ~core_clk;
   instr_exec instr_exec_i (.core_clk, .rst, .op_valid, .op_code, .imm_operand, .bit_select,
      .mem_addr, .mem_rdata, .table_pointer, .pc_page, .prog_rdata, .prog_addr, .mem_we,
      .mem_waddr, .mem_wdata, .work_register, .flags, .table_high_byte_reg, .skip_pending,
      .dummy_cycle);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // called at a falling edge; returns after the edge that takes the op
   task automatic run(input logic [3:0] c, input logic [7:0] i, input logic [7:0] m);
      op_valid = 1'b1;
      op_code = c;
      imm_operand = i;
      mem_rdata = m;
      @(negedge core_clk);
   endtask
   task automatic t_arith;
      run(`OP_XOR_IMM, 8'h35, 8'h00);
      chk({work_register, flags}, {8'h35, 4'h0});
      run(`OP_SUB_IMM, 8'h36, 8'h00);
      chk({work_register, flags}, {8'hff, 4'h0});
      run(`OP_SUB_IMM, 8'h7f, 8'h00);
      chk({work_register, flags}, {8'h80, 4'h3});
      run(`OP_SUB_IMM, 8'h01, 8'h00);
      chk({work_register, flags}, {8'h7f, 4'h9});
      run(`OP_SUB_IMM, 8'h7f, 8'h00);
      chk({work_register, flags}, {8'h00, 4'h7});
      run(`OP_XOR_MEM, 8'h00, 8'h0f);
      chk({work_register, flags, mem_we}, {8'h0f, 4'h3, 1'b0});
      run(`OP_XOR_INTO_MEM, 8'h00, 8'h0f);
      chk({work_register, flags, mem_we, mem_wdata}, {8'h0f, 4'h7, 1'b1, 8'h00});
   endtask
   task automatic t_swap;
      run(`OP_SWAP, 8'h00, 8'ha5);
      chk({flags, mem_we, mem_waddr, mem_wdata}, {4'h7, 1'b1, 9'h012, 8'h5a});
      run(`OP_SWAP_TO_WORK, 8'h00, 8'hc3);
      chk({flags, mem_we, work_register}, {4'h7, 1'b0, 8'h3c});
   endtask
   task automatic t_skip;
      run(`OP_SKIP_ZERO, 8'h00, 8'h00);
      chk({flags, skip_pending, dummy_cycle}, {4'h7, 2'b11});
      run(`OP_XOR_IMM, 8'hff, 8'h00);
      chk({work_register, flags, mem_we, skip_pending, dummy_cycle}, {8'h3c, 4'h7, 3'b000});
      run(`OP_SKIP_ZERO, 8'h00, 8'h01);
      chk({skip_pending, dummy_cycle}, 2'b00);
      run(`OP_COPY_SKIP_ZERO, 8'h00, 8'h00);
      chk({work_register, flags, dummy_cycle}, {8'h00, 4'h7, 1'b1});
      run(`OP_NOP, 8'h00, 8'h00);
      run(`OP_COPY_SKIP_ZERO, 8'h00, 8'h9a);
      chk({work_register, dummy_cycle}, {8'h9a, 1'b0});
      run(`OP_SKIP_BIT_ZERO, 8'h00, 8'h08);
      chk(dummy_cycle, 1'b0);
      bit_select = 3'h7;
      run(`OP_SKIP_BIT_ZERO, 8'h00, 8'h7f);
      chk({flags, skip_pending, dummy_cycle}, {4'h7, 2'b11});
      run(`OP_NOP, 8'h00, 8'h00);
   endtask
   // second cycle repeats the table op, which must be ignored
   task automatic t_table(input logic [3:0] c, input logic [5:0] page, input logic [15:0] w);
      prog_rdata = w;
      run(c, 8'h00, 8'h00);
      chk(prog_addr, {page, 8'h34});
      run(c, 8'h00, 8'h00);
      chk({mem_we, mem_waddr, table_high_byte_reg, mem_wdata}, {1'b1, 9'h012, w});
      run(`OP_NOP, 8'h00, 8'h00);
   endtask
   // reset in the dummy cycle of a skip; the op at the first edge after release must run
   task automatic t_reset;
      run(`OP_SKIP_ZERO, 8'h00, 8'h00);
      rst = 1'b1;
      @(negedge core_clk);
      chk({work_register, flags, table_high_byte_reg, skip_pending, dummy_cycle}, 22'h0);
      chk({prog_addr, mem_we, mem_waddr, mem_wdata}, 32'h0);
      rst = 1'b0;
      run(`OP_XOR_IMM, 8'h5a, 8'h00);
      chk({work_register, flags, dummy_cycle}, {8'h5a, 4'h0, 1'b0});
      run(`OP_NOP, 8'h00, 8'h00);
   endtask
   task automatic end_of_test;
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      t_arith();
      t_swap();
      t_skip();
      t_table(`OP_TABLE_CURRENT, 6'h05, 16'hbe7f);
      t_table(`OP_TABLE_LAST, 6'h3f, 16'h1234);
      t_reset();
      end_of_test();
   end
endmodule
